// [acp_pkg.sv]
// acp_pkg: constants, field positions and carrier types of the serial configuration port
// assumes: shared by the configuration port top and its testbench
package acp_pkg;

  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned BUF_DEPTH = 4;

  // address/command byte fields
  localparam int unsigned CMD_SIDE_BIT = 6;
  localparam logic CMD_SIDE_X = 1'b1;

  // channel control byte fields
  localparam int unsigned CTL_AS0 = 7;
  localparam int unsigned CTL_AS1 = 6;
  localparam int unsigned CTL_IDLE = 5;
  localparam int unsigned CTL_ALRST = 4;
  localparam int unsigned CTL_BYP = 3;
  localparam int unsigned CTL_UA = 2;
  localparam int unsigned CTL_AS2 = 1;
  localparam int unsigned CTL_CPEX = 0;

  // frame lengths and reset values
  localparam logic [2:0] LEN_SHORT = 3'h2;
  localparam logic [2:0] LEN_LONG = 3'h4;
  localparam logic [2:0] LEN_OVER = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [BYTE_W-1:0] CTRL_RST = 8'h20;
  localparam logic [BYTE_W-1:0] SLOT_RST = 8'h00;
  localparam logic [BYTE_W-1:0] SLOT_HW = 8'h00;

  typedef struct packed {
    logic [BYTE_W-1:0] ctrl;
    logic [BYTE_W-1:0] in_slot;
    logic [BYTE_W-1:0] out_slot;
  } acp_chan_cfg_t;

  typedef struct packed {
    logic mode_strap_select;
    logic [ADDR_W-1:0] strap_address;
  } acp_straps_t;

  localparam acp_chan_cfg_t CFG_RST = '{ctrl: CTRL_RST, in_slot: SLOT_RST, out_slot: SLOT_RST};

endpackage : acp_pkg

// [acp_sync.sv]
// acp_sync: two-flop level synchroniser, width and reset value set by parameters
// assumes: input is a level from another clock domain or a pin
`timescale 1ns/1ps
`default_nettype none
module acp_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // the first stage is read only by the second stage
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule : acp_sync
`default_nettype wire

// [acp_config_port.sv]
// acp_config_port: write-only 3-wire configuration port and channel configuration store
// assumes: sclk runs only inside frames, chip select high for 3+ clk_sys cycles between frames
//
// Contract
// - reset reinitialises all configuration state
// - reset clears control bits except idle bit
// - reset sets idle bit on both channels
// - mode strap high: serial writes accepted
// - mode strap low: serial ignored, pins drive
// - hardware mode uses time slot zero
// - frames are exactly two or four bytes
// - two bytes: command then control byte
// - four bytes: command, control, input, output slots
// - six address bits compared with straps
// - address mismatch discards following bytes
// - match accepts control and two slot bytes
// - command bit six picks channel side
// - data outputs tri-stated during updates
// - channel uses programmed input and output slots
// - data clocks from 256kHz to 4.096MHz
// - each side has its own control register
// - channels configured independently of each other
// - data sampled on sclk rise, LSB first
// - chip select low for whole frame
// - side bit one means X, zero Y
`timescale 1ns/1ps
`default_nettype none
module acp_config_port
  import acp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic config_serial_input,
  input wire logic mode_strap_select,
  input wire logic [ADDR_W-1:0] strap_address,
  output acp_chan_cfg_t x_cfg,
  output acp_chan_cfg_t y_cfg,
  output logic x_dout_oe_n,
  output logic y_dout_oe_n
);

  function automatic logic [BYTE_W-1:0] hw_ctrl(input logic as0, input logic as1, input logic ua,
                                                 input logic cpex);
    logic [BYTE_W-1:0] c;
    c = '0;
    c[CTL_AS0] = as0;
    c[CTL_AS1] = as1;
    c[CTL_UA] = ua;
    c[CTL_CPEX] = cpex;
    return c;
  endfunction : hw_ctrl

  // ---------------- serial clock domain ----------------
  // chip select high ends the frame flag asynchronously, since sclk stops between frames
  logic frame_rst_n;
  logic frame_act_reg;
  logic frame_tgl_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  logic [BYTE_W-1:0] shift_reg;
  logic [BYTE_W-1:0] byte_buf_reg [BUF_DEPTH];
  logic [2:0] cur_bit;
  logic [2:0] cur_byte;
  logic [BYTE_W-1:0] shift_next;

  assign frame_rst_n = arst_n & ~cs_n;
  assign cur_bit = frame_act_reg ? bit_cnt_reg : 3'h0;
  assign cur_byte = frame_act_reg ? byte_cnt_reg : 3'h0;
  assign shift_next = {config_serial_input, shift_reg[BYTE_W-1:1]};

  always_ff @(posedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      frame_act_reg <= 1'b0;
    else
      frame_act_reg <= 1'b1;
  end

  // counters survive chip select so the system side can read them after the frame
  always_ff @(posedge sclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      frame_tgl_reg <= 1'b0;
    end
    else if (!cs_n)
    begin
      shift_reg <= shift_next;
      bit_cnt_reg <= cur_bit + 3'h1;
      if (!frame_act_reg)
        frame_tgl_reg <= ~frame_tgl_reg;
      if (cur_bit == BIT_LAST)
        byte_cnt_reg <= (cur_byte >= LEN_LONG) ? LEN_OVER : cur_byte + 3'h1;
      else
        byte_cnt_reg <= cur_byte;
    end
  end

  always_ff @(posedge sclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < BUF_DEPTH; i++)
        byte_buf_reg[i] <= 8'h00;
    end
    else if (cur_bit == BIT_LAST && cur_byte < LEN_LONG)
      byte_buf_reg[cur_byte[1:0]] <= shift_next;
  end

  // ---------------- system clock domain ----------------
  logic cs_s;
  logic tgl_s;
  acp_straps_t straps_s;
  logic [1:0] pins_s;

  acp_sync #(.W(1), .RST_VAL(1'b1)) u_sync_cs (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .d(cs_n),
    .q(cs_s)
  );

  acp_sync #(.W(1), .RST_VAL(1'b0)) u_sync_tgl (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .d(frame_tgl_reg),
    .q(tgl_s)
  );

  // reset to software mode so no pin level enables an output right after reset
  acp_sync #(.W(ADDR_W + 1), .RST_VAL({1'b1, {ADDR_W{1'b0}}})) u_sync_straps (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .d({mode_strap_select, strap_address}),
    .q(straps_s)
  );

  acp_sync #(.W(2), .RST_VAL(2'h0)) u_sync_pins (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .d({config_serial_input, cs_n}),
    .q(pins_s)
  );

  logic cs_q_reg;
  logic tgl_seen_reg;
  logic frame_end;
  logic addr_hit;
  logic len_ok;
  logic frame_ok;
  logic to_x;
  logic busy;
  acp_chan_cfg_t sw_x_reg;
  acp_chan_cfg_t sw_y_reg;
  acp_chan_cfg_t x_cfg_reg;
  acp_chan_cfg_t y_cfg_reg;
  acp_chan_cfg_t wr_cfg;
  logic x_oe_n_reg;
  logic y_oe_n_reg;

  // sclk-side bytes and counts are quiet once chip select has been seen high
  assign frame_end = cs_s & ~cs_q_reg & (tgl_s != tgl_seen_reg);
  assign addr_hit = byte_buf_reg[0][ADDR_W-1:0] == straps_s.strap_address;
  assign len_ok = (byte_cnt_reg == LEN_SHORT || byte_cnt_reg == LEN_LONG) && bit_cnt_reg == 3'h0;
  assign frame_ok = frame_end & straps_s.mode_strap_select & addr_hit & len_ok;
  assign to_x = byte_buf_reg[0][CMD_SIDE_BIT] == CMD_SIDE_X;
  assign busy = straps_s.mode_strap_select & ~cs_s;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_q_reg <= 1'b1;
      tgl_seen_reg <= 1'b0;
    end
    else
    begin
      cs_q_reg <= cs_s;
      if (cs_s & ~cs_q_reg)
        tgl_seen_reg <= tgl_s;
    end
  end

  // a short write leaves the slot bytes as they were
  always_comb
  begin
    wr_cfg = to_x ? sw_x_reg : sw_y_reg;
    wr_cfg.ctrl = byte_buf_reg[1];
    if (byte_cnt_reg == LEN_LONG)
    begin
      wr_cfg.in_slot = byte_buf_reg[2];
      wr_cfg.out_slot = byte_buf_reg[3];
    end
  end

  // separate stores per side keep the two channels independent
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sw_x_reg <= CFG_RST;
      sw_y_reg <= CFG_RST;
    end
    else if (frame_ok)
    begin
      if (to_x)
        sw_x_reg <= wr_cfg;
      else
        sw_y_reg <= wr_cfg;
    end
  end

  // hardware mode: pins feed control bits, all slots are zero
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      x_cfg_reg <= CFG_RST;
      y_cfg_reg <= CFG_RST;
    end
    else if (straps_s.mode_strap_select)
    begin
      x_cfg_reg <= sw_x_reg;
      y_cfg_reg <= sw_y_reg;
    end
    else
    begin
      x_cfg_reg <= '{ctrl: hw_ctrl(straps_s.strap_address[0], straps_s.strap_address[1],
                     straps_s.strap_address[2], pins_s[1]), in_slot: SLOT_HW, out_slot: SLOT_HW};
      y_cfg_reg <= '{ctrl: hw_ctrl(straps_s.strap_address[3], straps_s.strap_address[4],
                     straps_s.strap_address[5], pins_s[0]), in_slot: SLOT_HW, out_slot: SLOT_HW};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      x_oe_n_reg <= 1'b1;
      y_oe_n_reg <= 1'b1;
    end
    else
    begin
      x_oe_n_reg <= busy | x_cfg_reg.ctrl[CTL_IDLE];
      y_oe_n_reg <= busy | y_cfg_reg.ctrl[CTL_IDLE];
    end
  end

  assign x_cfg = x_cfg_reg; // slot indices hold at any data clock rate
  assign y_cfg = y_cfg_reg;
  assign x_dout_oe_n = x_oe_n_reg;
  assign y_dout_oe_n = y_oe_n_reg;

  // ---------------- checks ----------------
  logic rst_seen_reg;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      rst_seen_reg <= 1'b0;
    else
      rst_seen_reg <= 1'b1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  AST_RESET_DEFAULT: assert property (!rst_seen_reg |-> sw_x_reg == CFG_RST && sw_y_reg == CFG_RST)
    else $error("configuration not at reset default");
  AST_BUSY_TRISTATE: assert property (busy ##1 busy |-> x_dout_oe_n && y_dout_oe_n)
    else $error("data output driven during update");
  AST_HW_SLOTS: assert property (!straps_s.mode_strap_select |=> x_cfg.in_slot == SLOT_HW
                                 && x_cfg.out_slot == SLOT_HW && y_cfg.in_slot == SLOT_HW
                                 && y_cfg.out_slot == SLOT_HW)
    else $error("hardware mode slot not zero");
  AST_HW_IGNORE: assert property (!straps_s.mode_strap_select |=> $stable(sw_x_reg) && $stable(sw_y_reg))
    else $error("serial write taken in hardware mode");
  AST_X_WRITE: assert property (frame_ok && to_x |=> sw_x_reg.ctrl == $past(byte_buf_reg[1])
                                && $stable(sw_y_reg))
    else $error("X control byte not written");
  AST_Y_WRITE: assert property (frame_ok && !to_x |=> sw_y_reg.ctrl == $past(byte_buf_reg[1])
                                && $stable(sw_x_reg))
    else $error("Y control byte not written");
  AST_NOMATCH: assert property (frame_end && !addr_hit |=> $stable(sw_x_reg) && $stable(sw_y_reg))
    else $error("mismatched frame changed configuration");
  AST_BAD_LEN: assert property (frame_end && !len_ok |=> $stable(sw_x_reg) && $stable(sw_y_reg))
    else $error("bad length frame changed configuration");
  AST_SHORT_SLOTS: assert property (frame_ok && byte_cnt_reg == LEN_SHORT |=> $stable(sw_x_reg.in_slot)
                                    && $stable(sw_x_reg.out_slot) && $stable(sw_y_reg.in_slot)
                                    && $stable(sw_y_reg.out_slot))
    else $error("short write changed slots");
  AST_LONG_SLOTS: assert property (frame_ok && byte_cnt_reg == LEN_LONG |=>
                                   ($past(to_x) ? sw_x_reg.in_slot : sw_y_reg.in_slot) == $past(byte_buf_reg[2])
                                   && ($past(to_x) ? sw_x_reg.out_slot : sw_y_reg.out_slot) == $past(byte_buf_reg[3]))
    else $error("long write slots wrong");
  AST_SW_FOLLOW: assert property (frame_ok && to_x ##1 straps_s.mode_strap_select |=>
                                  x_cfg.ctrl == $past(byte_buf_reg[1], 2))
    else $error("X output config not updated");

  COV_SHORT_X: cover property (frame_ok && to_x && byte_cnt_reg == LEN_SHORT);
  COV_LONG_Y: cover property (frame_ok && !to_x && byte_cnt_reg == LEN_LONG);
  COV_MISMATCH: cover property (frame_end && !addr_hit);
  COV_HW_MODE: cover property (!straps_s.mode_strap_select ##1 !straps_s.mode_strap_select);

endmodule : acp_config_port
`default_nettype wire

// [acp_host_model.sv]
// acp_host_model: host controller on the 3-wire configuration bus
// assumes: frames are sent by task call; sclk stands still between frames
`timescale 1ns/1ps
`default_nettype none
module acp_host_model (
  output var logic sclk,
  output var logic cs_n,
  output var logic ser_data
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    ser_data = 1'b0;
  end
  // static levels, used while these lines serve as control pins
  task set_pins(input logic cs, input logic d);
    cs_n = cs;
    ser_data = d;
  endtask : set_pins
  // n bytes, byte0 in bits 7:0; 160 ns sclk, only inside the frame
  task send(input logic [31:0] data, input int n);
    #37;
    cs_n = 1'b0;
    for (int i = 0; i < 8 * n; i++)
    begin
      ser_data = data[i];
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    // released line shows no stale level
    ser_data = ~ser_data;
    // gap well above the 3 clk_sys minimum
    #200;
  endtask : send
endmodule : acp_host_model
`default_nettype wire

// [test_acp_config_port.sv]
// test_acp_config_port: self-checking bench of the configuration port
// assumes: acp_host_model drives the serial lines, 40 MHz clk_sys
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("unexpected %s exp %h got %h", nm, e, g); \
    end \
  end
module test_acp_config_port;
  import acp_pkg::*;
  localparam logic [5:0] MY_ADDR = 6'h2D;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic mode_strap_select = 1'b1;
  logic [ADDR_W-1:0] strap_address = MY_ADDR;
  wire logic sclk;
  wire logic cs_n;
  wire logic ser_data;
  acp_chan_cfg_t x_cfg;
  acp_chan_cfg_t y_cfg;
  logic x_oe_n;
  logic y_oe_n;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  always #12.5 clk_sys = ~clk_sys;
  acp_host_model host_u (.sclk(sclk), .cs_n(cs_n), .ser_data(ser_data));
  acp_config_port dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
    .config_serial_input(ser_data), .mode_strap_select(mode_strap_select), .strap_address(strap_address),
    .x_cfg(x_cfg), .y_cfg(y_cfg), .x_dout_oe_n(x_oe_n), .y_dout_oe_n(y_oe_n));
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  always @(posedge clk_sys)
  begin
    cyc++;
    // whole run needs about 1040 cycles
    if (cyc == 8000)
    begin
      n_errors++;
      $display("unexpected timeout");
      test_done();
    end
  end
  task do_reset;
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1; // hold kept short: after a stable clock, two edges suffice here
    repeat (8) @(posedge clk_sys);
  endtask : do_reset
  task t_reset;
    `CHK("x_cfg", 24'h200000, x_cfg)
    `CHK("y_cfg", 24'h200000, y_cfg)
    `CHK("x_oe_n", 1'b1, x_oe_n)
    `CHK("y_oe_n", 1'b1, y_oe_n)
    $display("test reset done");
  endtask : t_reset
  task t_short_x;
    host_u.send({16'h0, 8'h0A, 2'b01, MY_ADDR}, 2);
    repeat (4) @(posedge clk_sys);
    `CHK("x_cfg", 24'h0A0000, x_cfg)
    `CHK("y_cfg", 24'h200000, y_cfg)
    `CHK("x_oe_n", 1'b0, x_oe_n)
    $display("test short x done");
  endtask : t_short_x
  task t_long_y;
    fork
      host_u.send({8'h1F, 8'h05, 8'h01, 2'b00, MY_ADDR}, 4);
      begin
        repeat (40) @(posedge clk_sys);
        `CHK("x_oe_n busy", 1'b1, x_oe_n)
      end
    join
    repeat (4) @(posedge clk_sys);
    `CHK("y_cfg", 24'h01051F, y_cfg)
    `CHK("x_cfg", 24'h0A0000, x_cfg)
    `CHK("x_oe_n", 1'b0, x_oe_n)
    `CHK("y_oe_n", 1'b0, y_oe_n)
    host_u.send({16'h0, 8'h21, 2'b00, MY_ADDR}, 2);
    repeat (4) @(posedge clk_sys);
    `CHK("y_cfg keep", 24'h21051F, y_cfg)
    `CHK("y_oe_n idle", 1'b1, y_oe_n)
    $display("test long y done");
  endtask : t_long_y
  task t_refuse;
    host_u.send({16'h0, 8'hFF, 2'b01, MY_ADDR ^ 6'h01}, 2);
    host_u.send({8'h0, 8'h07, 8'hFF, 2'b01, MY_ADDR}, 3);
    repeat (4) @(posedge clk_sys);
    `CHK("x_cfg refused", 24'h0A0000, x_cfg)
    @(posedge clk_sys);
    strap_address <= 6'h12;
    repeat (4) @(posedge clk_sys);
    host_u.send({16'h0, 8'h0C, 2'b01, 6'h12}, 2);
    repeat (4) @(posedge clk_sys);
    `CHK("x_cfg new addr", 24'h0C0000, x_cfg)
    strap_address <= MY_ADDR;
    repeat (4) @(posedge clk_sys);
    $display("test refuse done");
  endtask : t_refuse
  task t_hw_mode;
    @(posedge clk_sys);
    mode_strap_select <= 1'b0;
    repeat (6) @(posedge clk_sys);
    host_u.send({16'h0, 8'h33, 2'b01, MY_ADDR}, 2);
    host_u.set_pins(1'b1, 1'b0);
    repeat (8) @(posedge clk_sys);
    // straps 2D: x takes bits 0..2 and serial data, y bits 3..5 and cs_n
    `CHK("x_cfg hw", 24'h840000, x_cfg)
    `CHK("y_cfg hw", 24'h850000, y_cfg)
    mode_strap_select <= 1'b1;
    repeat (8) @(posedge clk_sys);
    `CHK("x_cfg sw", 24'h0C0000, x_cfg)
    do_reset();
    `CHK("x_cfg reset", 24'h200000, x_cfg)
    `CHK("y_cfg reset", 24'h200000, y_cfg)
    $display("test hardware mode done");
  endtask : t_hw_mode
  initial
  begin
    do_reset();
    t_reset();
    t_short_x();
    t_long_y();
    t_refuse();
    t_hw_mode();
    test_done();
  end
endmodule : test_acp_config_port
`default_nettype wire
